/* bench/isw_gate_load.sv */
`timescale 1ns/1ps
// ****************
// External switch gate
// ****************
module isw_gate_load
(
	// Clock
	input wire logic clk,
	// Gate pin
	input wire logic gate,
	// Turn-on events seen
	output int pulses
);
	logic prev_r = 1'b0;
	initial pulses = 0;
	always @(negedge clk)
	begin
		if (gate === 1'b1 && prev_r === 1'b0)
			pulses <= pulses + 1;
		prev_r <= gate;
	end
endmodule

/* bench/test_isolated_switch_enable_logic.sv */
`timescale 1ns/1ps
module test_isolated_switch_enable_logic;
	import isw_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic en = 1'b0;
	logic two = 1'b0;
	logic os = 1'b0;
	logic [2:0] lvl = 3'h0;
	logic [2:0] l0;
	isw_supply_t sup = 4'h0;
	logic gate, koff, xfer;
	isw_cfg_t cfg;
	int pulses, p0, hi, cyc = 0, seed = 85, n_mismatch = 0, checks_done = 0;
	always #25 clk = ~clk;
	isw_enable_ctl dut_u (.clk(clk), .reset(reset), .enable_in(en), .wire_mode_two(two), .one_shot_variant(os),
		.power_level_select(lvl), .supplies(sup), .gate_drive_out(gate), .keep_off(koff),
		.power_transfer_on(xfer), .cfg(cfg));
	isw_gate_load load_u (.clk(clk), .gate(gate), .pulses(pulses));
	// ****************
	// Helpers
	// ****************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic count_hi(input int n);
		hi = 0;
		repeat (n)
		begin
			@(negedge clk);
			hi += (gate === 1'b1);
		end
	endtask
	task automatic power_up(input logic t, input logic o);
		reset = 1'b1;
		two = t;
		os = o;
		en = t;
		sup = 4'he;
		lvl = 3'($random(seed));
		l0 = lvl;
		wait_n(16);
		chk({gate, koff, xfer, cfg}, {3'b010, 4'h0});
		reset = 1'b0;
		wait_n(4);
		chk(cfg, {t, l0});
	endtask
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 12000)
		begin
			n_mismatch++;
			stop_test();
		end
	end
	// ****************
	// Scenarios
	// ****************
	initial
	begin
		power_up(1'b0, 1'b0);
		lvl = ~l0;
		two = 1'b1;
		wait_n(3);
		chk(cfg, {1'b0, l0});
		repeat (200)
		begin
			en = 1'($random(seed));
			wait_n(2);
			chk(gate, en);
		end
		en = 1'b1;
		sup.over_temp = 1'b1;
		wait_n(2);
		chk({gate, xfer}, 2'b00);
		wait_n(5);
		chk(gate, 1'b0);
		sup.over_temp = 1'b0;
		wait_n(2);
		chk({gate, xfer}, 2'b11);
		sup.secondary_mid_rail = 1'b0;
		wait_n(2);
		chk(gate, 1'b0);
		sup = 4'ha;
		wait_n(2);
		chk({gate, koff}, 2'b01);
		sup = 4'he;
		wait_n(3);
		sup = 4'h6;
		wait_n(ISW_LOSS_CYC - 5);
		chk(gate, 1'b1);
		wait_n(10);
		chk({gate, koff}, 2'b01);
		$display("Standard three-wire test done");
		power_up(1'b0, 1'b1);
		p0 = pulses;
		en = 1'b1;
		count_hi(ISW_PULSE_CYC + 50);
		chk(hi, ISW_PULSE_CYC + 1);
		count_hi(100);
		chk(hi, 0);
		chk(pulses - p0, 1);
		en = 1'b0;
		wait_n(2);
		en = 1'b1;
		wait_n(20);
		chk(gate, 1'b1);
		sup.over_temp = 1'b1;
		wait_n(2);
		chk(gate, 1'b0);
		$display("One-shot test done");
		power_up(1'b1, 1'b1);
		count_hi(300);
		chk(hi, 300);
		en = 1'b0;
		sup.primary_supply = 1'b0;
		wait_n(2);
		chk(gate, 1'b0);
		$display("Two-wire test done");
		stop_test();
	end
endmodule

/* design/isw_enable_ctl.sv */
`timescale 1ns/1ps
module isw_enable_ctl
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Pins and sensors
	input wire logic enable_in,
	input wire logic wire_mode_two,
	input wire logic one_shot_variant,
	input wire logic [2:0] power_level_select,
	input wire isw_pkg::isw_supply_t supplies,
	// Outputs
	output logic gate_drive_out,
	output logic keep_off,
	output logic power_transfer_on,
	output isw_pkg::isw_cfg_t cfg
);
	import isw_pkg::*;

	// ****************************************
	// State
	// ****************************************
	isw_state_t state_r, state_nxt;
	isw_cfg_t cfg_r, cfg_nxt;
	logic en_prev_r, en_prev_nxt;
	logic [ISW_CNT_W-1:0] loss_r, loss_nxt;
	logic lost_r, lost_nxt;
	logic gate_r, gate_nxt;
	logic keep_r, keep_nxt;
	logic xfer_r, xfer_nxt;
	logic one_shot_mode;
	logic rise;
	logic block_now;
	logic pulse_busy;

	// ****************************************
	// Conditions
	// ****************************************
	assign one_shot_mode = one_shot_variant && !cfg_r.two_wire;
	assign rise = enable_in && !en_prev_r;
	assign block_now = supplies.over_temp || !supplies.secondary_high_rail
		|| !supplies.secondary_mid_rail || lost_nxt;

	isw_pulse u_pulse
	(
		.clk(clk),
		.reset(reset),
		.start(state_r == ISW_ST_RUN && one_shot_mode && rise && !block_now),
		.kill(block_now),
		.busy(pulse_busy)
	);

	// ****************************************
	// Next values
	// ****************************************
	always_comb
	begin
		state_nxt = state_r;
		cfg_nxt = cfg_r;
		en_prev_nxt = enable_in;
		loss_nxt = loss_r;
		lost_nxt = lost_r;
		case (state_r)
			ISW_ST_POWERUP:
			begin
				if (supplies.primary_supply)
				begin
					cfg_nxt.two_wire = wire_mode_two;
					cfg_nxt.level = power_level_select;
					state_nxt = ISW_ST_RUN;
				end
			end
			ISW_ST_RUN:
			begin
			end
			default:
				state_nxt = ISW_ST_POWERUP;
		endcase
		if (supplies.primary_supply)
		begin
			loss_nxt = ISW_CNT_ZERO;
			lost_nxt = 1'b0;
		end
		else if (loss_r == ISW_CNT_W'(ISW_LOSS_CYC - 1))
			lost_nxt = 1'b1;
		else
			loss_nxt = loss_r + ISW_CNT_ONE;
		xfer_nxt = supplies.primary_supply && !supplies.over_temp;
		keep_nxt = !supplies.secondary_high_rail || lost_nxt;
		if (state_r != ISW_ST_RUN || block_now)
			gate_nxt = 1'b0;
		else if (one_shot_mode)
			gate_nxt = pulse_busy || (rise && !block_now);
		else
			gate_nxt = enable_in;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_r <= ISW_ST_POWERUP;
			cfg_r <= '{two_wire: 1'b0, level: ISW_LEVEL_RST};
			en_prev_r <= 1'b0;
			loss_r <= ISW_CNT_ZERO;
			lost_r <= 1'b0;
			gate_r <= 1'b0;
			keep_r <= 1'b1;
			xfer_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cfg_r <= cfg_nxt;
			en_prev_r <= en_prev_nxt;
			loss_r <= loss_nxt;
			lost_r <= lost_nxt;
			gate_r <= gate_nxt;
			keep_r <= keep_nxt;
			xfer_r <= xfer_nxt;
		end
	end

	assign gate_drive_out = gate_r;
	assign keep_off = keep_r;
	assign power_transfer_on = xfer_r;
	assign cfg = cfg_r;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_rise_run;
		state_r == ISW_ST_RUN && one_shot_mode && rise && !block_now;
	endsequence

	a_temp_xfer_off: assert property (@(posedge clk) disable iff (reset) supplies.over_temp |=> !power_transfer_on)
		else $error("transfer during over-temperature");
	a_temp_gate_low: assert property (@(posedge clk) disable iff (reset) supplies.over_temp |=> !gate_drive_out)
		else $error("gate high during over-temperature");
	a_temp_resume: assert property (@(posedge clk) disable iff (reset)
		(!supplies.over_temp && supplies.primary_supply) |=> power_transfer_on)
		else $error("transfer did not resume");
	a_std_follow: assert property (@(posedge clk) disable iff (reset)
		(state_r == ISW_ST_RUN && !one_shot_mode && !block_now) |=> gate_drive_out == $past(enable_in))
		else $error("gate not following enable");
	a_shot_pulse: assert property (@(posedge clk) disable iff (reset)
		s_rise_run ##1 (!block_now && enable_in)[*1] |=> gate_drive_out)
		else $error("one-shot pulse missing");
	a_shot_two_wire: assert property (@(posedge clk) disable iff (reset) cfg_r.two_wire |-> !one_shot_mode)
		else $error("one-shot in two-wire mode");
	a_rail_keep_off: assert property (@(posedge clk) disable iff (reset)
		!supplies.secondary_high_rail |=> keep_off && !gate_drive_out)
		else $error("keep-off not applied");
	a_loss_timeout: assert property (@(posedge clk) disable iff (reset)
		lost_r |-> !gate_drive_out && keep_off)
		else $error("gate on after primary loss");
	a_mode_held: assert property (@(posedge clk) disable iff (reset)
		(state_r == ISW_ST_RUN) |=> $stable(cfg_r))
		else $error("config changed after power-up");
	a_mid_rail_low: assert property (@(posedge clk) disable iff (reset) !supplies.secondary_mid_rail |=> !gate_drive_out)
		else $error("gate high with mid rail down");
endmodule

/* design/isw_pkg.sv */
package isw_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int ISW_CLK_HZ = 20000000;
	localparam int ISW_PULSE_NS = 10000;
	localparam int ISW_PULSE_CYC = (ISW_PULSE_NS * (ISW_CLK_HZ / 1000000) + 999) / 1000;
	localparam int ISW_LOSS_US = 50;
	localparam int ISW_LOSS_CYC = ISW_LOSS_US * (ISW_CLK_HZ / 1000000);
	localparam int ISW_CNT_W = 12;
	localparam logic [ISW_CNT_W-1:0] ISW_CNT_ZERO = 12'h000;
	localparam logic [ISW_CNT_W-1:0] ISW_CNT_ONE = 12'h001;
	localparam logic [2:0] ISW_LEVEL_RST = 3'h0;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0]
	{
		ISW_ST_POWERUP = 2'b00,
		ISW_ST_RUN = 2'b01
	} isw_state_t;

	typedef struct packed
	{
		logic primary_supply;
		logic secondary_high_rail;
		logic secondary_mid_rail;
		logic over_temp;
	} isw_supply_t;

	typedef struct packed
	{
		logic two_wire;
		logic [2:0] level;
	} isw_cfg_t;

endpackage

/* design/isw_pulse.sv */
`timescale 1ns/1ps
module isw_pulse
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic kill,
	// Status
	output logic busy
);
	import isw_pkg::*;

	logic [ISW_CNT_W-1:0] cnt_r;
	logic [ISW_CNT_W-1:0] cnt_nxt;

	always_comb
	begin
		cnt_nxt = cnt_r;
		if (kill)
			cnt_nxt = ISW_CNT_ZERO;
		else if (start)
			cnt_nxt = ISW_CNT_W'(ISW_PULSE_CYC);
		else if (cnt_r != ISW_CNT_ZERO)
			cnt_nxt = cnt_r - ISW_CNT_ONE;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			cnt_r <= ISW_CNT_ZERO;
		else
			cnt_r <= cnt_nxt;
	end

	assign busy = (cnt_r != ISW_CNT_ZERO);

	a_pulse_kill: assert property (@(posedge clk) disable iff (reset) kill |=> !busy)
		else $error("pulse survived kill");
	a_pulse_len: assert property (@(posedge clk) disable iff (reset)
		(start && !kill) |=> busy && cnt_r == ISW_CNT_W'(ISW_PULSE_CYC))
		else $error("pulse length wrong");
endmodule
